/* tb/pgt_mcu_model.sv */
// model of the powered microcontroller that reports completion
// assumes it wakes on each falling gate edge and drives done at negedges
module pgt_mcu_model (
   input wire logic sys_clk_i,
   input wire logic gate_drive_n_i,
   input wire logic [15:0] delay_i,
   input wire logic [3:0] pulses_i,
   output logic done_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int k;
   // count latched at wake-up; extra pulses probe the ignore logic
   initial begin
      done_o = 1'b0;
      forever begin
         @(negedge gate_drive_n_i);
         k = int'(pulses_i);
         repeat (delay_i) @(negedge sys_clk_i);
         for (int i = 0; i < k; i++) begin
            done_o = 1'b1;
            repeat (12) @(negedge sys_clk_i);
            done_o = 1'b0;
            repeat (12) @(negedge sys_clk_i);
         end
      end
   end
endmodule

/* tb/tb.sv */
// self-checking bench of the power gating interval timer
// assumes a shortened millisecond of 10 cycles; times counted in cycles
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int CPM = 10;
   logic sys_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic periodic_mode_i = 1'b1;
   logic manual_power_on_i = 1'b0;
   logic [16:0] interval_ticks_i = 17'h00002;
   logic done, gate, meas, per;
   logic [16:0] ticks_o;
   logic [15:0] delay = 16'h0000;
   logic [3:0] pulses = 4'h0;
   int n_fail = 0;
   int comparisons = 0;
   int cyc = 0;
   int n, t, d;
   always #5 sys_clk_i = ~sys_clk_i;
   pgt_timer #(.CYC_PER_MS(CPM)) uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
      .periodic_mode_i(periodic_mode_i), .done_i(done),
      .manual_power_on_i(manual_power_on_i), .interval_ticks_i(interval_ticks_i),
      .gate_drive_n_o(gate), .measuring_o(meas), .periodic_o(per),
      .interval_ticks_o(ticks_o));
   pgt_mcu_model mcu (.sys_clk_i(sys_clk_i), .gate_drive_n_i(gate), .delay_i(delay),
      .pulses_i(pulses), .done_o(done));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // snap a count to its expectation when within sampling jitter
   function automatic logic [31:0] near(input int got, input int exp);
      return (got >= exp - 15 && got <= exp + 15) ? exp : got;
   endfunction
   function automatic logic [16:0] clamp(input logic [16:0] v);
      return (v < 17'h00001) ? 17'h00001 : (v > 17'h11940) ? 17'h11940 : v;
   endfunction
   task automatic wait_gate(input logic lvl, input int lim);
      n = 0;
      while (gate !== lvl && n < lim) begin
         @(negedge sys_clk_i);
         n++;
      end
   endtask
   task automatic start(input logic mode, input logic [16:0] v);
      periodic_mode_i = mode;
      interval_ticks_i = v;
      rst_n_i = 1'b0;
      repeat (3) @(negedge sys_clk_i);
      chk({gate, meas, per}, 3'b110);
      rst_n_i = 1'b1;
   endtask
   task automatic meas_fall(input logic mode, input logic [16:0] v);
      start(mode, v);
      wait_gate(1'b0, 1300);
      chk(near(n, 100 * CPM), 100 * CPM);
      chk(meas, 1'b0);
      chk(ticks_o, clamp(v));
      chk(per, mode);
   endtask
   task automatic end_of_test;
      if (n_fail == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         end_of_test();
      end
   end
   initial begin
      void'($urandom(32'h312e));
      meas_fall(1'b1, 17'h00002);
      wait_gate(1'b1, 2000);
      chk(near(n, 1500), 1500);
      d = $urandom_range(300, 20);
      delay = 16'(d);
      pulses = 4'h2;
      wait_gate(1'b0, 1000);
      chk(near(n, 500), 500);
      wait_gate(1'b1, 1600);
      // two synchroniser stages plus the gate register after the pin rises
      chk(near(n, d + 2), d + 2);
      t = n;
      pulses = 4'h0;
      wait_gate(1'b0, 2500);
      chk(near(t + n, 2000), 2000);
      repeat (100) @(negedge sys_clk_i);
      manual_power_on_i = 1'b1;
      repeat (300) @(negedge sys_clk_i);
      manual_power_on_i = 1'b0;
      wait_gate(1'b1, 2000);
      chk(near(400 + n, 1500), 1500);
      // manual request in the periodic off phase
      manual_power_on_i = 1'b1;
      wait_gate(1'b0, 300);
      chk(near(n, 200), 200);
      manual_power_on_i = 1'b0;
      wait_gate(1'b1, 2500);
      chk(near(n, 1700), 1700);
      t = $urandom_range(3, 1);
      meas_fall(1'b0, 17'(t));
      wait_gate(1'b1, 4000);
      chk(near(n, t * 1000 - 500), t * 1000 - 500);
      manual_power_on_i = 1'b1;
      repeat (100) @(negedge sys_clk_i);
      manual_power_on_i = 1'b0;
      wait_gate(1'b0, 500);
      chk(n, 500);
      delay = 16'h0032;
      pulses = 4'h1;
      manual_power_on_i = 1'b1;
      wait_gate(1'b0, 300);
      chk(near(n, 200), 200);
      wait_gate(1'b1, 3800);
      chk(n, 3800);
      manual_power_on_i = 1'b0;
      pulses = 4'h0;
      wait_gate(1'b1, 4000);
      chk(near(n, 200 + t * 1000 - 500), 200 + t * 1000 - 500);
      manual_power_on_i = 1'b1;
      start(1'b1, 17'h00000);
      repeat (500) @(negedge sys_clk_i);
      chk({meas, gate}, 2'b11);
      manual_power_on_i = 1'b0;
      wait_gate(1'b0, 2000);
      chk(near(n, 1200), 1200);
      chk(ticks_o, 17'h00001);
      wait_gate(1'b1, 1000);
      chk(near(n, 500), 500);
      meas_fall(1'b1, 17'h1FFFF);
      end_of_test();
   end
endmodule

/* verilog/pgt_cfg.svh */
// timing and range constants of the power gating interval timer
// assumes a 100 MHz system clock; counts below are in milliseconds unless marked ns, MHz or ticks
`ifndef PGT_CFG_SVH
`define PGT_CFG_SVH
// clock rate in MHz and one millisecond in ns
`define PGT_CLK_MHZ 100
`define PGT_MS_NS 1000000
// cycles per millisecond, derived from the two above
`define PGT_CYC_PER_MS (`PGT_MS_NS * `PGT_CLK_MHZ / 1000)
// least completion pulse, ns (sampled by the two-stage synchroniser)
`define PGT_DONE_MIN_NS 100
// final gate-off time: 50 ms
`define PGT_OFF_MS 24'h000032
// manual request debounce: 20 ms, observation window 30 ms
`define PGT_DEB_MS 5'h14
`define PGT_WIN_MS 5'h1E
// manual request to gate low: at most 10 ms; the code waits out the 20 ms debounce first
`define PGT_REACT_MS 4'hA
// resistor measurement: 100 ms typical, 120 ms worst
`define PGT_MEAS_MS 7'h64
`define PGT_MEAS_MAX_MS 7'h78
// one interval tick is 100 ms
`define PGT_TICK_MS 24'h000064
// interval range in ticks: 100 ms to 7200 s
`define PGT_IP_MIN 17'h00001
`define PGT_IP_MAX 17'h11940
`endif

/* verilog/pgt_pkg.sv */
// types of the power gating interval timer
// assumes pgt_cfg.svh supplies the numeric constants
package pgt_pkg;
   typedef enum logic [2:0] {
      PGT_MEASURE  = 3'h0,
      PGT_WAIT_REL = 3'h1,
      PGT_IDLE     = 3'h2,
      PGT_ON       = 3'h3,
      PGT_OFF      = 3'h4,
      PGT_HOLD     = 3'h5
   } pgt_state_e;

   // synchronised pin levels
   typedef struct packed {
      logic done;
      logic manual;
      logic periodic;
   } pgt_pins_s;

   typedef logic [23:0] pgt_ms_t;
   typedef logic [16:0] pgt_ticks_t;
endpackage

/* verilog/pgt_timer.sv */
// power gating interval timer: measure, periodic / one-shot gate drive,
// completion handling and debounced manual power-on
// assumes pins arrive asynchronously and the interval code from the
// resistor digitizer is static while measuring
//
// Behaviour
// - mode high: gate on every interval
// - gate output low means load powered
// - gate low interval minus 50 ms
// - accepted completion drives gate high immediately
// - completion taken on rising edge only
// - only first completion per interval counts
// - gate high until measurement ends
// - gate pulled low when interval begins
// - one measurement after reset before gating
// - mode level taken when measurement completes
// - mode low: single pulse after power-up
// - one-shot: manual request gives one pulse
// - manual request debounced, 20 ms high
// - gate low once the request is debounced, 20 ms after it
// - manual request ignored while gate low
// - manual request clears counters until release
// - completion ignored while manual input high
// - manual during measurement restarts measurement after release
// - periodic falling edges spaced one interval
// - interval between 100 ms and 7200 s
// - quadratic resistor law lives in digitizer
// - measurement lasts 100 ms, under 120
// - interval codes come from the digitizer
`include "pgt_cfg.svh"

module pgt_timer #(
   parameter int CYC_PER_MS = `PGT_CYC_PER_MS
) (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   input wire logic periodic_mode_i,
   input wire logic done_i,
   input wire logic manual_power_on_i,
   input wire logic [16:0] interval_ticks_i,
   output logic gate_drive_n_o,
   output logic measuring_o,
   output logic periodic_o,
   output logic [16:0] interval_ticks_o
);

   pgt_pkg::pgt_pins_s pins_meta;
   pgt_pkg::pgt_pins_s pins;
   logic done_prev;
   pgt_pkg::pgt_ticks_t ticks_meta;
   pgt_pkg::pgt_ticks_t ticks_sync;

   pgt_pkg::pgt_state_e state;
   pgt_pkg::pgt_state_e next_state;
   logic [16:0] presc;
   logic [16:0] next_presc;
   pgt_pkg::pgt_ms_t elapsed;
   pgt_pkg::pgt_ms_t next_elapsed;
   logic [6:0] meas_ms;
   logic [6:0] next_meas_ms;
   logic gate_n;
   logic next_gate_n;
   logic done_seen;
   logic next_done_seen;
   logic periodic;
   logic next_periodic;
   pgt_pkg::pgt_ticks_t ticks;
   pgt_pkg::pgt_ticks_t next_ticks;
   logic man_deb;
   logic next_man_deb;
   logic [4:0] stab_cnt;
   logic [4:0] next_stab_cnt;

   logic tick;
   logic man_rise;
   logic done_rise;
   pgt_pkg::pgt_ms_t interval_ms;
   pgt_pkg::pgt_ms_t on_ms;
   logic meas_reg;
   logic next_meas_reg;

   // two-stage synchronisers; edge detect reads only the second stage
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         pins_meta <= '0;
         pins <= '0;
         done_prev <= 1'b0;
         ticks_meta <= '0;
         ticks_sync <= '0;
      end else begin
         pins_meta <= '{done: done_i, manual: manual_power_on_i,
                        periodic: periodic_mode_i};
         pins <= pins_meta;
         done_prev <= pins.done;
         ticks_meta <= interval_ticks_i;
         ticks_sync <= ticks_meta;
      end
   end

   assign tick = (presc == 17'(CYC_PER_MS - 1));
   assign done_rise = pins.done && !done_prev;
   assign interval_ms = 24'(ticks) * `PGT_TICK_MS;
   assign on_ms = interval_ms - `PGT_OFF_MS;

   // millisecond prescaler and manual-input debounce on both edges
   always_comb begin
      next_presc = tick ? 17'h00000 : presc + 17'h00001;
      next_man_deb = man_deb;
      next_stab_cnt = 5'h00;
      man_rise = 1'b0;
      if (pins.manual != man_deb) begin
         next_stab_cnt = stab_cnt;
         if (tick) begin
            if (stab_cnt == `PGT_DEB_MS - 5'h01) begin
               next_man_deb = pins.manual;
               next_stab_cnt = 5'h00;
               man_rise = pins.manual;
            end else begin
               next_stab_cnt = stab_cnt + 5'h01;
            end
         end
      end
   end

   // main sequence
   always_comb begin
      next_state = state;
      next_elapsed = elapsed;
      next_meas_ms = meas_ms;
      next_gate_n = gate_n;
      next_done_seen = done_seen;
      next_periodic = periodic;
      next_ticks = ticks;
      unique case (state)
         pgt_pkg::PGT_MEASURE: begin
            next_gate_n = 1'b1;
            if (man_deb) begin
               next_state = pgt_pkg::PGT_WAIT_REL;
               next_meas_ms = 7'h00;
            end else if (tick) begin
               if (meas_ms == `PGT_MEAS_MS - 7'h01) begin
                  // latch interval and mode, clamped to the legal range
                  // the code itself comes from the digitizer
                  if (ticks_sync < `PGT_IP_MIN) begin
                     next_ticks = `PGT_IP_MIN;
                  end else if (ticks_sync > `PGT_IP_MAX) begin
                     next_ticks = `PGT_IP_MAX;
                  end else begin
                     next_ticks = ticks_sync;
                  end
                  next_periodic = pins.periodic;
                  next_state = pgt_pkg::PGT_ON;
                  next_gate_n = 1'b0;
                  next_elapsed = 24'h000000;
                  next_done_seen = 1'b0;
               end else begin
                  next_meas_ms = meas_ms + 7'h01;
               end
            end
         end
         pgt_pkg::PGT_WAIT_REL: begin
            next_gate_n = 1'b1;
            if (!man_deb) begin
               next_state = pgt_pkg::PGT_MEASURE;
               next_meas_ms = 7'h00;
            end
         end
         pgt_pkg::PGT_ON: begin
            // manual requests are not decoded while the load is on
            next_gate_n = 1'b0;
            if (done_rise && !done_seen && !man_deb) begin
               next_gate_n = 1'b1;
               next_done_seen = 1'b1;
               next_state = periodic ? pgt_pkg::PGT_OFF : pgt_pkg::PGT_IDLE;
               if (tick) begin
                  next_elapsed = elapsed + 24'h000001;
               end
            end else if (tick) begin
               next_elapsed = elapsed + 24'h000001;
               if (elapsed == on_ms - 24'h000001) begin
                  next_gate_n = 1'b1;
                  next_state = periodic ? pgt_pkg::PGT_OFF : pgt_pkg::PGT_IDLE;
               end
            end
         end
         pgt_pkg::PGT_OFF: begin
            next_gate_n = 1'b1;
            if (man_rise) begin
               next_state = pgt_pkg::PGT_HOLD;
               next_gate_n = 1'b0;
               next_elapsed = 24'h000000;
            end else if (tick) begin
               if (elapsed == interval_ms - 24'h000001) begin
                  next_elapsed = 24'h000000;
                  next_gate_n = 1'b0;
                  next_done_seen = 1'b0;
                  next_state = pgt_pkg::PGT_ON;
               end else begin
                  next_elapsed = elapsed + 24'h000001;
               end
            end
         end
         pgt_pkg::PGT_IDLE: begin
            next_gate_n = 1'b1;
            if (man_rise) begin
               next_state = pgt_pkg::PGT_HOLD;
               next_gate_n = 1'b0;
               next_elapsed = 24'h000000;
            end
         end
         pgt_pkg::PGT_HOLD: begin
            // counters held clear, completion ignored until release
            next_gate_n = 1'b0;
            next_elapsed = 24'h000000;
            if (!man_deb) begin
               next_state = pgt_pkg::PGT_ON;
               next_done_seen = 1'b0;
            end
         end
         default: begin
            next_state = pgt_pkg::PGT_MEASURE;
            next_gate_n = 1'b1;
            next_meas_ms = 7'h00;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         state <= pgt_pkg::PGT_MEASURE;
         presc <= 17'h00000;
         elapsed <= 24'h000000;
         meas_ms <= 7'h00;
         gate_n <= 1'b1;
         done_seen <= 1'b0;
         periodic <= 1'b0;
         ticks <= `PGT_IP_MIN;
         man_deb <= 1'b0;
         stab_cnt <= 5'h00;
      end else begin
         state <= next_state;
         presc <= next_presc;
         elapsed <= next_elapsed;
         meas_ms <= next_meas_ms;
         gate_n <= next_gate_n;
         done_seen <= next_done_seen;
         periodic <= next_periodic;
         ticks <= next_ticks;
         man_deb <= next_man_deb;
         stab_cnt <= next_stab_cnt;
      end
   end

   assign gate_drive_n_o = gate_n;
   assign measuring_o = meas_reg;
   assign next_meas_reg = (next_state == pgt_pkg::PGT_MEASURE) ||
                          (next_state == pgt_pkg::PGT_WAIT_REL);
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         meas_reg <= 1'b1;
      end else begin
         meas_reg <= next_meas_reg;
      end
   end
   assign periodic_o = periodic;
   assign interval_ticks_o = ticks;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   gate_off_measure_a: assert property (
      state == pgt_pkg::PGT_MEASURE |-> gate_n)
      else $error("gate low while measuring");
   done_ends_on_a: assert property (
      state == pgt_pkg::PGT_ON && done_rise && !done_seen && !man_deb
      |=> gate_n && done_seen)
      else $error("completion did not end on-period");
   on_time_end_a: assert property (
      state == pgt_pkg::PGT_ON && tick && elapsed == on_ms - 24'h000001
      |=> gate_n ##0 state != pgt_pkg::PGT_ON)
      else $error("gate not released 50 ms before interval end");
   period_restart_a: assert property (
      state == pgt_pkg::PGT_OFF && !man_rise && tick
      && elapsed == interval_ms - 24'h000001
      |=> !gate_n && elapsed == 24'h000000 && !done_seen)
      else $error("interval did not restart on time");
   manual_fast_a: assert property (
      man_rise && (state == pgt_pkg::PGT_IDLE || state == pgt_pkg::PGT_OFF)
      |=> !gate_n && state == pgt_pkg::PGT_HOLD)
      else $error("manual request did not switch load on");
   manual_ignored_a: assert property (
      man_rise && state == pgt_pkg::PGT_ON |=> state != pgt_pkg::PGT_HOLD)
      else $error("manual request taken while gate low");
   hold_counters_a: assert property (
      state == pgt_pkg::PGT_HOLD && $past(state) == pgt_pkg::PGT_HOLD
      |-> elapsed == 24'h000000 && !gate_n)
      else $error("counters not clear during manual hold");
   hold_no_done_a: assert property (
      (state == pgt_pkg::PGT_HOLD || state == pgt_pkg::PGT_ON) && man_deb && done_rise
      && !tick |=> !gate_n)
      else $error("completion ended manual hold");
   abort_measure_a: assert property (
      state == pgt_pkg::PGT_MEASURE && man_deb |=> state == pgt_pkg::PGT_WAIT_REL
      ##0 meas_ms == 7'h00)
      else $error("measurement not aborted");
   interval_held_a: assert property (
      state != pgt_pkg::PGT_MEASURE |=> $stable(ticks) && $stable(periodic))
      else $error("interval changed after measurement");
   interval_range_a: assert property (
      ticks >= `PGT_IP_MIN && ticks <= `PGT_IP_MAX)
      else $error("interval out of range");
   debounce_time_a: assert property (
      $changed(man_deb) |-> $past(tick) && $past(stab_cnt) == `PGT_DEB_MS - 5'h01)
      else $error("manual level changed before debounce time");
   one_shot_idle_a: assert property (
      state == pgt_pkg::PGT_IDLE && !man_rise |=> gate_n && !periodic)
      else $error("one-shot gate pulsed without request");
   done_once_a: assert property (
      done_seen && done_rise && state == pgt_pkg::PGT_OFF && !tick
      |=> done_seen && state == pgt_pkg::PGT_OFF)
      else $error("second completion acted upon");
endmodule
